// file: rtl/afi_card.sv
// Purpose: converter input card with 17-word fifo, output holding register and status
// Assumes: one clock; processor instructions arrive as AXI4-Lite writes and data-register reads, dma cycles on a pulse port
// Notes:   converter pins are synchronised before use
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "afi_consts.svh"

module afi_card #(
   parameter int DEPTH = `AFI_FIFO_DEPTH
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic                 dma_input_cycle,
   output logic [15:0]               dma_data,
   output logic                      dma_data_valid,
   output logic                      dma_service_req,
   input  wire afi_pkg::afi_dev_in_t dev_in,
   output afi_pkg::afi_dev_out_t     dev_out,
   output afi_pkg::afi_leds_t        leds,
   output logic                      irq
);
   // 1.25 Mwords/s at 10 MHz leaves 8 clocks per word; the sync chain needs 2 per level
   localparam int MIN_WORD_CYC = `AFI_CLK_KHZ / `AFI_MAX_RATE_KW;
   localparam int LW = $clog2(DEPTH+1);

   // converter pin synchroniser
   logic [15:0] word_s1_q;
   logic [15:0] word_s2_q;
   logic        strb_s1_q;
   logic        strb_s2_q;
   logic        strb_d1_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word_s1_q <= 16'h0000;
         word_s2_q <= 16'h0000;
         strb_s1_q <= 1'b1;
         strb_s2_q <= 1'b1;
         strb_d1_q <= 1'b1;
      end else begin
         word_s1_q <= dev_in.word;
         word_s2_q <= word_s1_q;
         strb_s1_q <= dev_in.strobe_n;
         strb_s2_q <= strb_s1_q;
         strb_d1_q <= strb_s2_q;
      end
   end

   // data is stable by the time the flag has fallen through two stages
   wire strb_fall = strb_d1_q && !strb_s2_q;

   // bus write channel
   logic       aw_held_q;
   logic       w_held_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic       bvalid_q;
   logic [1:0] bresp_q;
   logic       awready_q;
   logic       wready_q;

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;
   wire wr_go   = aw_held_q && w_held_q && !bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
      end else begin
         // ready from a flop: low while the channel is held or about to be
         awready_q <= !(aw_take || (aw_held_q && !wr_go));
         wready_q  <= !(w_take || (w_held_q && !wr_go));
         if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_q <= 1'b0;
         end
         if (w_take) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;

   wire wr_cmd   = wr_go && (aw_addr_q == `AFI_OFF_CMD);
   wire wr_outw  = wr_go && (aw_addr_q == `AFI_OFF_OUTW);
   wire wr_istat = wr_go && (aw_addr_q == `AFI_OFF_ISTAT);
   wire wr_imask = wr_go && (aw_addr_q == `AFI_OFF_IMASK);
   wire wr_known = wr_cmd || wr_outw || wr_istat || wr_imask ||
                   (aw_addr_q == `AFI_OFF_STAT) || (aw_addr_q == `AFI_OFF_DATA) ||
                   (aw_addr_q == `AFI_OFF_LEVEL);

   wire set_ctl  = wr_cmd && w_strb_q[0] && w_data_q[`AFI_CMD_STC];
   wire clr_ctl  = wr_cmd && w_strb_q[0] && w_data_q[`AFI_CMD_CLC];
   wire clr_flg  = wr_cmd && w_strb_q[0] && w_data_q[`AFI_CMD_CLF];
   wire ctl_rst  = wr_cmd && w_strb_q[0] && w_data_q[`AFI_CMD_CRS];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `AFI_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_known ? `AFI_RESP_OKAY : `AFI_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // control, input-active and device command
   logic ctrl_q;
   logic act_q;
   logic cmd_q;
   logic push_q;

   always_ff @(posedge aclk) begin
      if (!aresetn || ctl_rst || clr_ctl)
         ctrl_q <= 1'b0;
      else if (set_ctl)
         ctrl_q <= 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || ctl_rst || clr_ctl)
         act_q <= 1'b0;
      else if (set_ctl || clr_flg)
         act_q <= 1'b1;
   end

   // fifo and read paths
   logic [15:0]   head;
   logic          fifo_full;
   logic          fifo_empty;
   logic [LW-1:0] fifo_level;
   logic          arready_q;
   logic          rvalid_q;
   logic          rd_pop;

   wire push = strb_fall && act_q && !fifo_full;
   wire dma_pop = dma_input_cycle && !fifo_empty;

   afi_fifo #(
      .WIDTH (16),
      .DEPTH (DEPTH)
   ) u_fifo (
      .aclk  (aclk),
      .clr   (!aresetn || ctl_rst),
      .push  (push),
      .wdata (word_s2_q),
      .pop   (dma_pop || rd_pop),
      .rdata (head),
      .full  (fifo_full),
      .empty (fifo_empty),
      .level (fifo_level)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn || ctl_rst || clr_ctl)
         cmd_q <= 1'b0;
      else if (strb_fall)
         cmd_q <= 1'b0;
      else if (set_ctl)
         cmd_q <= 1'b1;
      // re-issue a clock after the word lands, so the flag that withdrew it goes first
      else if (ctrl_q && push_q)
         cmd_q <= 1'b1;
   end

   // dma returns the head word one cycle after the request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_data       <= 16'h0000;
         dma_data_valid <= 1'b0;
         push_q         <= 1'b0;
      end else begin
         dma_data       <= head;
         dma_data_valid <= dma_pop;
         push_q         <= push;
      end
   end

   // bus read channel; a data-register read is the load-input instruction
   afi_pkg::afi_rd_state_t rd_st_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [31:0] rd_mux;
   logic        rd_ok;

   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire ld_read = ar_take && (s_axi_araddr == `AFI_OFF_DATA);
   assign rd_pop = ld_read && !fifo_empty && !dma_input_cycle;
   // a dma cycle in the same clock wins the head; the read reports an empty attempt
   wire rd_empty = ld_read && (fifo_empty || dma_input_cycle);

   logic [15:0] outw_q;
   logic [3:0]  ist_q;
   logic [3:0]  imask_q;
   logic        ovr_q;

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_ok  = 1'b1;
      if (s_axi_araddr == `AFI_OFF_CMD) begin
         rd_mux = 32'h0000_0000;
      end else if (s_axi_araddr == `AFI_OFF_STAT) begin
         rd_mux[`AFI_ST_FLAG] = !fifo_empty;
         rd_mux[`AFI_ST_CTRL] = ctrl_q;
         rd_mux[`AFI_ST_ACT]  = act_q;
         rd_mux[`AFI_ST_OVR]  = ovr_q;
         rd_mux[`AFI_ST_CMD]  = cmd_q;
      end else if (s_axi_araddr == `AFI_OFF_DATA) begin
         rd_mux = {16'h0000, head};
      end else if (s_axi_araddr == `AFI_OFF_OUTW) begin
         rd_mux = {16'h0000, outw_q};
      end else if (s_axi_araddr == `AFI_OFF_ISTAT) begin
         rd_mux = {28'h0000000, ist_q};
      end else if (s_axi_araddr == `AFI_OFF_IMASK) begin
         rd_mux = {28'h0000000, imask_q};
      end else if (s_axi_araddr == `AFI_OFF_LEVEL) begin
         rd_mux = {{(32-LW){1'b0}}, fifo_level};
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_st_q   <= afi_pkg::AFI_RD_IDLE;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `AFI_RESP_OKAY;
      end else begin
         case (rd_st_q)
            afi_pkg::AFI_RD_IDLE: begin
               arready_q <= !ar_take;
               if (ar_take) begin
                  rd_st_q  <= afi_pkg::AFI_RD_RESP;
                  rvalid_q <= 1'b1;
                  rdata_q  <= rd_empty ? 32'h0000_0000 : rd_mux;
                  rresp_q  <= rd_ok ? `AFI_RESP_OKAY : `AFI_RESP_SLVERR;
               end
            end
            default: begin
               if (s_axi_rready) begin
                  rd_st_q   <= afi_pkg::AFI_RD_IDLE;
                  arready_q <= 1'b1;
                  rvalid_q  <= 1'b0;
               end
            end
         endcase
      end
   end

   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // overrun: push onto full, or read from empty
   wire ovr_evt = (strb_fall && act_q && fifo_full) || rd_empty ||
                  (dma_input_cycle && fifo_empty);

   always_ff @(posedge aclk) begin
      if (!aresetn || ctl_rst)
         ovr_q <= 1'b0;
      else if (ovr_evt)
         ovr_q <= 1'b1;
   end

   // output holding register
   always_ff @(posedge aclk) begin
      if (!aresetn)
         outw_q <= 16'h0000;
      else if (wr_outw) begin
         if (w_strb_q[0])
            outw_q[7:0] <= w_data_q[7:0];
         if (w_strb_q[1])
            outw_q[15:8] <= w_data_q[15:8];
      end
   end

   // interrupt status: set wins over write-one-to-clear
   wire [3:0] ev = {wr_outw, !fifo_empty, ovr_evt, push};

   always_ff @(posedge aclk) begin
      if (!aresetn)
         ist_q <= 4'h0;
      else
         ist_q <= ev | (ist_q & ~((wr_istat && w_strb_q[0]) ? w_data_q[3:0] : 4'h0));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         imask_q <= 4'h0;
      else if (wr_imask && w_strb_q[0])
         imask_q <= w_data_q[3:0];
   end

   // pin and indicator outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dev_out         <= '{word: 16'h0000, cmd_o: 1'b0, cmd_oe_n: 1'b1};
         leds            <= '0;
         irq             <= 1'b0;
         dma_service_req <= 1'b0;
      end else begin
         dev_out.word     <= outw_q;
         dev_out.cmd_o    <= 1'b0;
         dev_out.cmd_oe_n <= !cmd_q;
         leds.not_empty   <= !fifo_empty;
         leds.overrun     <= ovr_q;
         leds.cmd_active  <= cmd_q;
         dma_service_req  <= !fifo_empty && !dma_pop && !rd_pop;
         // eight clocks per word at full rate stay ahead of the three-clock strobe path
         irq              <= |(ist_q & imask_q) || (ctrl_q && !fifo_empty && MIN_WORD_CYC > 2);
      end
   end
endmodule : afi_card

// file: rtl/afi_consts.svh
// Purpose: constants for the converter fifo io card
// Assumes: AXI4-Lite register map, 32-bit data
// Notes:   offsets are byte addresses
`ifndef AFI_CONSTS_SVH
`define AFI_CONSTS_SVH
`define AFI_OFF_CMD     8'h00
`define AFI_OFF_STAT    8'h04
`define AFI_OFF_DATA    8'h08
`define AFI_OFF_OUTW    8'h0c
`define AFI_OFF_ISTAT   8'h10
`define AFI_OFF_IMASK   8'h14
`define AFI_OFF_LEVEL   8'h18
`define AFI_CMD_STC     0
`define AFI_CMD_CLC     1
`define AFI_CMD_CLF     2
`define AFI_CMD_CRS     3
`define AFI_ST_FLAG     0
`define AFI_ST_CTRL     1
`define AFI_ST_ACT      2
`define AFI_ST_OVR      3
`define AFI_ST_CMD      4
`define AFI_EV_WORD     0
`define AFI_EV_OVR      1
`define AFI_EV_NE       2
`define AFI_EV_W        3
`define AFI_FIFO_DEPTH  17
`define AFI_MAX_RATE_KW 1250
`define AFI_CLK_KHZ     10000
`define AFI_RESP_OKAY   2'b00
`define AFI_RESP_SLVERR 2'b10
`endif

// file: rtl/afi_pkg.sv
// Purpose: shared types for the converter fifo io card
// Assumes: afi_consts.svh included for the figures
// Notes:   types only
package afi_pkg;
   typedef struct packed {
      logic [15:0] word;
      logic        strobe_n;
   } afi_dev_in_t;
   typedef struct packed {
      logic [15:0] word;
      logic        cmd_o;
      logic        cmd_oe_n;
   } afi_dev_out_t;
   typedef struct packed {
      logic not_empty;
      logic overrun;
      logic cmd_active;
   } afi_leds_t;
   typedef enum logic [1:0] {
      AFI_RD_IDLE,
      AFI_RD_RESP
   } afi_rd_state_t;
endpackage : afi_pkg

// file: rtl/afi_fifo.sv
// Purpose: first-in first-out store for converter words
// Assumes: caller never pushes when full nor pops when empty
// Notes:   push and pop may coincide
`timescale 1ns/1ps
module afi_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 17
) (
   input  wire logic             aclk,
   input  wire logic             clr,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] rdata,
   output logic                  full,
   output logic                  empty,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [$clog2(DEPTH+1)-1:0] cnt_q;

   always_ff @(posedge aclk) begin
      if (push)
         mem_q[wr_q] <= wdata;
   end

   always_ff @(posedge aclk) begin
      if (clr) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   assign rdata = mem_q[rd_q];
   assign empty = (cnt_q == '0);
   assign full  = (cnt_q == ($clog2(DEPTH+1))'(DEPTH));
   assign level = cnt_q;
endmodule : afi_fifo

// file: test/afi_card_checker.sv
// Purpose: concurrent checks on the converter fifo io card ports
// Assumes: one clock, synchronous active-low reset
// Notes:   windows allow for the synchroniser and output registers
`timescale 1ns/1ps
module afi_card_checker #(
   parameter int DEPTH = 17
) (
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  s_axi_wvalid,
   input wire logic                  dma_input_cycle,
   input wire logic                  dma_data_valid,
   input wire logic                  dma_service_req,
   input wire afi_pkg::afi_dev_in_t  dev_in,
   input wire afi_pkg::afi_dev_out_t dev_out,
   input wire afi_pkg::afi_leds_t    leds,
   input wire logic                  irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_cmd_drive_low: assert property (!dev_out.cmd_o)
      else $error("command drive value not low");
   a_cmd_led_lit: assert property (!dev_out.cmd_oe_n |-> ##[0:1] leds.cmd_active)
      else $error("command indicator dark while command active");
   a_flag_withdraws_cmd: assert property ($fell(dev_in.strobe_n) |-> ##[1:6] dev_out.cmd_oe_n)
      else $error("device flag did not withdraw command");
   a_reset_clean: assert property ($rose(aresetn) |-> dev_out.cmd_oe_n && !leds.not_empty && !leds.overrun && !irq)
      else $error("state left over after reset");
   a_dma_one_word: assert property (dma_input_cycle && dma_service_req |=> dma_data_valid)
      else $error("dma cycle gave no word");
   a_dma_word_cause: assert property (dma_data_valid |-> $past(dma_input_cycle))
      else $error("word delivered without dma cycle");
   a_overrun_sticky: assert property (leds.overrun |=> leds.overrun || $past(s_axi_wvalid, 2)
      || $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4))
      else $error("overrun cleared without a write");
   a_word_needs_flag: assert property ($rose(leds.not_empty) |-> !$past(dev_in.strobe_n, 2)
      || !$past(dev_in.strobe_n, 3) || !$past(dev_in.strobe_n, 4))
      else $error("word entered without device flag");
   a_req_with_flag: assert property ($rose(dma_service_req) |-> ##[0:2] leds.not_empty)
      else $error("service request without not-empty");

   cover property ($rose(leds.overrun));
   cover property (dma_data_valid);
   cover property ($rose(irq));
endmodule : afi_card_checker

bind afi_card afi_card_checker #(.DEPTH(DEPTH)) chk (.*);

// file: test/afi_conv_model.sv
// Purpose: converter side of the card, offers one word per flag pulse
// Assumes: word stable 4 cycles (13 when slow) before the flag falls, flag low 4 cycles
// Notes:   word lines are inverted once the hold has run out
`timescale 1ns/1ps
module afi_conv_model (
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic            cmd_oe_n,
   input  wire logic            go,
   input  wire logic            slow,
   output afi_pkg::afi_dev_in_t dev_in,
   output logic [7:0]           sent
);
   logic [4:0] cnt_q;
   logic       busy_q;
   logic [4:0] fall_at;

   assign fall_at = slow ? 5'd12 : 5'd3;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_q          <= 1'b0;
         cnt_q           <= 5'd0;
         sent            <= 8'h00;
         dev_in.word     <= 16'hffff;
         dev_in.strobe_n <= 1'b1;
      end else if (!busy_q) begin
         // a pending command or an outside trigger starts a word
         if (go || !cmd_oe_n) begin
            busy_q      <= 1'b1;
            cnt_q       <= 5'd0;
            dev_in.word <= 16'h5a00 + {8'h00, sent};
         end
      end else begin
         cnt_q <= cnt_q + 5'd1;
         if (cnt_q == fall_at) begin
            dev_in.strobe_n <= 1'b0;
         end
         if (cnt_q == fall_at + 5'd4) begin
            dev_in.strobe_n <= 1'b1;
            dev_in.word     <= ~dev_in.word;
            sent            <= sent + 8'h01;
            busy_q          <= 1'b0;
         end
      end
   end
endmodule : afi_conv_model

// file: test/adc_fifo_io_interface_test.sv
// Purpose: self-checking bench for the converter fifo io card
// Assumes: afi_conv_model stands in for the converter
// Notes:   bready and rready stay high, so any answer is taken at once
`timescale 1ns/1ps
`include "afi_consts.svh"
module adc_fifo_io_interface_test;
   logic                  aclk, aresetn, go, slow, dma_input_cycle, dma_data_valid, dma_service_req, irq;
   logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]            s_axi_awaddr, s_axi_araddr, sent, base;
   logic [31:0]           s_axi_wdata, s_axi_rdata, d;
   logic [3:0]            s_axi_wstrb;
   logic [1:0]            s_axi_bresp, s_axi_rresp;
   logic [15:0]           dma_data;
   afi_pkg::afi_dev_in_t  dev_in;
   afi_pkg::afi_dev_out_t dev_out;
   afi_pkg::afi_leds_t    leds;
   int                    fail_count, checked, cycles;

   afi_card dut (.*);
   afi_conv_model conv (.aclk(aclk), .aresetn(aresetn), .cmd_oe_n(dev_out.cmd_oe_n), .go(go), .slow(slow),
                        .dev_in(dev_in), .sent(sent));

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= v;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid);
      check("write response", `AFI_RESP_OKAY, s_axi_bresp);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
         end
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      check("read response", er, s_axi_rresp);
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   // one outside-triggered word, then time for it to land
   task automatic pulse_go();
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      tick(30);
   endtask : pulse_go

   task automatic t_reset();
      rd(`AFI_OFF_STAT, `AFI_RESP_OKAY);
      check("status", 32'h0, d);
      check("command line", 1'b1, dev_out.cmd_oe_n);
      check("leds", 3'b000, leds);
      rd(8'h1c, `AFI_RESP_SLVERR);
      $display("test reset finished");
   endtask : t_reset

   task automatic t_output();
      wr(`AFI_OFF_OUTW, 32'h0000c3a5);
      tick(3);
      check("output bus", 16'hc3a5, dev_out.word);
      wr(`AFI_OFF_IMASK, 32'h0);
      tick(20);
      check("output bus held", 16'hc3a5, dev_out.word);
      $display("test output finished");
   endtask : t_output

   task automatic t_gate();
      base = sent;
      slow <= 1'b1;
      pulse_go();
      rd(`AFI_OFF_LEVEL, `AFI_RESP_OKAY);
      check("level while inactive", 32'h0, d);
      wr(`AFI_OFF_CMD, 32'h1 << `AFI_CMD_CLF);
      pulse_go();
      check("not empty led", 1'b1, leds.not_empty);
      check("service request", 1'b1, dma_service_req);
      check("command line", 1'b1, dev_out.cmd_oe_n);
      rd(`AFI_OFF_STAT, `AFI_RESP_OKAY);
      check("status", 32'h5, d);
      rd(`AFI_OFF_DATA, `AFI_RESP_OKAY);
      check("read word", 16'h5a01 + 16'(base), d);
      tick(3);
      check("not empty led", 1'b0, leds.not_empty);
      rd(`AFI_OFF_DATA, `AFI_RESP_OKAY);
      check("empty read", 32'h0, d);
      tick(2);
      check("overrun led", 1'b1, leds.overrun);
      wr(`AFI_OFF_CMD, 32'h1 << `AFI_CMD_CRS);
      tick(2);
      rd(`AFI_OFF_STAT, `AFI_RESP_OKAY);
      check("status after control reset", 32'h0, d);
      $display("test gate finished");
   endtask : t_gate

   task automatic t_full();
      base = sent;
      slow <= 1'b0;
      wr(`AFI_OFF_CMD, 32'h1 << `AFI_CMD_STC);
      tick(2);
      check("command line", 1'b0, dev_out.cmd_oe_n);
      check("command led", 1'b1, leds.cmd_active);
      for (int n = 0; n < 1000 && sent != base + 8'd18; n++) begin
         @(posedge aclk);
      end
      check("words offered", base + 8'd18, sent);
      tick(10);
      rd(`AFI_OFF_LEVEL, `AFI_RESP_OKAY);
      check("level when full", 32'd17, d);
      check("overrun led", 1'b1, leds.overrun);
      check("command after drop", 1'b1, dev_out.cmd_oe_n);
      wr(`AFI_OFF_CMD, (32'h1 << `AFI_CMD_STC) | (32'h1 << `AFI_CMD_CLC));
      rd(`AFI_OFF_STAT, `AFI_RESP_OKAY);
      check("status clear wins", 32'h9, d);
      for (int i = 0; i < 17; i++) begin
         dma_input_cycle <= 1'b1;
         @(posedge aclk);
         dma_input_cycle <= 1'b0;
         @(posedge aclk);
         check("dma valid", 1'b1, dma_data_valid);
         check("dma word", 16'h5a00 + 16'(base) + 16'(i), dma_data);
         tick(2);
      end
      check("service request", 1'b0, dma_service_req);
      $display("test full finished");
   endtask : t_full

   task automatic t_irq();
      wr(`AFI_OFF_ISTAT, 32'hf);
      wr(`AFI_OFF_IMASK, 32'h1 << `AFI_EV_WORD);
      tick(2);
      check("irq idle", 1'b0, irq);
      wr(`AFI_OFF_CMD, 32'h1 << `AFI_CMD_CLF);
      pulse_go();
      check("irq on word", 1'b1, irq);
      wr(`AFI_OFF_IMASK, 32'h0);
      tick(2);
      check("irq masked", 1'b0, irq);
      wr(`AFI_OFF_IMASK, 32'h1 << `AFI_EV_WORD);
      tick(2);
      check("irq unmasked", 1'b1, irq);
      wr(`AFI_OFF_ISTAT, 32'h1 << `AFI_EV_WORD);
      tick(2);
      check("irq cleared", 1'b0, irq);
      rd(`AFI_OFF_DATA, `AFI_RESP_OKAY);
      $display("test interrupt finished");
   endtask : t_irq

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   initial begin
      {aresetn, go, slow, dma_input_cycle, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 7'h00;
      {s_axi_bready, s_axi_rready} = 2'b11;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      {fail_count, checked, cycles} = {32'd0, 32'd0, 32'd0};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_output();
      t_gate();
      t_full();
      t_irq();
      test_done();
   end
endmodule : adc_fifo_io_interface_test
